/* File: hw/deglitch_filter.sv */
// Symmetric deglitch filter for one slow input level
module deglitch_filter #(
  parameter int unsigned CNT_W   = supply_fail_pkg::DGL_W,
  parameter int unsigned DGL_CYC = supply_fail_pkg::DGL_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level in and filtered level out
  input  wire logic level_i,
  output logic      level_o
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DGL_CYC - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             level_r;
  logic             level_nxt;

  // Count cycles the input differs from the filtered level
  always_comb begin
    cnt_nxt   = '0;
    level_nxt = level_r;
    if (level_i != level_r) begin
      if (cnt_r == LAST) begin
        level_nxt = level_i;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  // Filtered level starts low, as with an open pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule : deglitch_filter

/* File: hw/supply_loss_fail_mode_control.sv */
// Supply-loss handling, mode selection and wake reporting of the switch
module supply_loss_fail_mode_control #(
  parameter int unsigned N_CH         = supply_fail_pkg::N_CH,
  parameter int unsigned N_DIRECT     = supply_fail_pkg::N_DIRECT,
  parameter int unsigned DGL_CYC      = supply_fail_pkg::DGL_CYC,
  parameter int unsigned WD_SHORT_CYC = supply_fail_pkg::WD_SHORT_CYC,
  parameter int unsigned WD_LONG_CYC  = supply_fail_pkg::WD_LONG_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // Supply and ground monitors
  input  wire logic                main_supply_ok_i,
  input  wire logic                logic_supply_ok_i,
  input  wire logic                logic_supply_in_range_i,
  input  wire logic                ground_ok_i,
  // Wake state and reset pin
  input  wire logic                awake_i,
  input  wire logic                wake_by_reset_i,
  input  wire logic                active_low_reset_in_b_i,
  // Two-way clock pin
  input  wire logic                clk_pin_i,
  output logic                     clk_pin_o,
  output logic                     clk_pin_oe_o,
  output logic                     clk_pin_level_o,
  // Direct pins
  input  wire logic                fail_force_i,
  input  wire logic [N_DIRECT-1:0] direct_channel_inputs_i,
  // Internal PWM and SPI configuration
  input  wire logic [N_CH-1:0]     pwm_channel_i,
  input  wire logic                ext_switch_cfg_i,
  input  wire logic                spi_frame_ok_i,
  input  wire logic                wd_sel_i,
  // Fault events and flag clears
  input  wire logic                open_load_evt_i,
  input  wire logic                short_vbat_evt_i,
  input  wire logic                severe_gnd_evt_i,
  input  wire logic                overcur_evt_i,
  input  wire logic                overtemp_evt_i,
  input  wire logic                clock_fail_evt_i,
  input  wire logic                undervolt_evt_i,
  input  wire logic                overvolt_evt_i,
  input  wire logic [7:0]          fault_clear_i,
  // Power outputs
  output logic [N_CH-1:0]          power_channel_outputs_o,
  output logic                     external_switch_drive_o,
  // Status
  output logic                     fail_mode_o,
  output logic                     spi_status_avail_o,
  output logic                     spi_fail_flag_o,
  output logic                     force_level_o,
  output logic [7:0]               fault_flags_o
);

  localparam int unsigned DW = supply_fail_pkg::DGL_W;
  localparam int unsigned WW = supply_fail_pkg::WD_W;

  // Widen direct inputs onto the channel vector
  function automatic logic [N_CH-1:0] to_channels(input logic [N_DIRECT-1:0] d);
    logic [N_CH-1:0] v;
    v = supply_fail_pkg::CH_OFF;
    for (int i = 0; i < N_DIRECT; i++) begin
      if (i < N_CH) begin
        v[i] = d[i];
      end
    end
    return v;
  endfunction : to_channels

  // Reset synchroniser
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Deglitched force and direct inputs
  logic                force_f;
  logic [N_DIRECT-1:0] direct_f;

  deglitch_filter #(
    .CNT_W   (DW),
    .DGL_CYC (DGL_CYC)
  ) u_force_dgl (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .level_i (fail_force_i),
    .level_o (force_f)
  );

  for (genvar g = 0; g < N_DIRECT; g++) begin : g_direct
    deglitch_filter #(
      .CNT_W   (DW),
      .DGL_CYC (DGL_CYC)
    ) u_dir_dgl (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .level_i (direct_channel_inputs_i[g]),
      .level_o (direct_f[g])
    );
  end

  // Mode state
  supply_fail_pkg::mode_t mode_r;
  supply_fail_pkg::mode_t mode_nxt;
  logic                   wd_expired_r;
  logic                   wd_expired_nxt;
  logic [WW-1:0]          wd_cnt_r;
  logic [WW-1:0]          wd_cnt_nxt;
  logic [WW-1:0]          wd_last;
  logic                   power_off;

  assign power_off = !main_supply_ok_i && !logic_supply_ok_i;

  // Watchdog: frames restart it; timeout or missing logic supply with main supply present expire it
  always_comb begin
    wd_last        = wd_sel_i ? WW'(WD_LONG_CYC - 1) : WW'(WD_SHORT_CYC - 1);
    wd_cnt_nxt     = wd_cnt_r;
    wd_expired_nxt = wd_expired_r;
    if (power_off) begin
      wd_cnt_nxt     = '0;
      wd_expired_nxt = 1'b0;
    end else if (!logic_supply_ok_i) begin
      wd_cnt_nxt     = '0;
      wd_expired_nxt = 1'b1;
    end else if (spi_frame_ok_i) begin
      wd_cnt_nxt     = '0;
      wd_expired_nxt = 1'b0;
    end else if (wd_cnt_r >= wd_last) begin
      wd_expired_nxt = 1'b1;
    end else begin
      wd_cnt_nxt = wd_cnt_r + WW'(1);
    end
  end

  // Mode selection by supplies, force input and watchdog
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      supply_fail_pkg::POWER_OFF,
      supply_fail_pkg::MAIN_LOST,
      supply_fail_pkg::NORMAL,
      supply_fail_pkg::FAIL_SAFE: begin
        if (power_off) begin
          mode_nxt = supply_fail_pkg::POWER_OFF;
        end else if (!main_supply_ok_i) begin
          mode_nxt = supply_fail_pkg::MAIN_LOST;
        end else if (force_f || wd_expired_nxt) begin
          mode_nxt = supply_fail_pkg::FAIL_SAFE;
        end else begin
          mode_nxt = supply_fail_pkg::NORMAL;
        end
      end
      default: begin
        mode_nxt = supply_fail_pkg::POWER_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r       <= supply_fail_pkg::POWER_OFF;
      wd_cnt_r     <= '0;
      wd_expired_r <= 1'b0;
    end else begin
      mode_r       <= mode_nxt;
      wd_cnt_r     <= wd_cnt_nxt;
      wd_expired_r <= wd_expired_nxt;
    end
  end

  // Output drive state
  logic [N_CH-1:0] ch_r;
  logic [N_CH-1:0] ch_nxt;
  logic            ext_r;
  logic            ext_nxt;
  logic            fail_r;
  logic            fail_nxt;

  // Channel and external switch drive by mode
  always_comb begin
    ch_nxt   = supply_fail_pkg::CH_OFF;
    ext_nxt  = 1'b0;
    fail_nxt = (mode_nxt == supply_fail_pkg::FAIL_SAFE);
    case (mode_nxt)
      supply_fail_pkg::POWER_OFF: begin
        ch_nxt  = supply_fail_pkg::CH_OFF;
        ext_nxt = 1'b0;
      end
      supply_fail_pkg::MAIN_LOST: begin
        ch_nxt  = supply_fail_pkg::CH_OFF;
        ext_nxt = ext_switch_cfg_i;
      end
      supply_fail_pkg::NORMAL: begin
        ch_nxt  = pwm_channel_i;
        ext_nxt = ext_switch_cfg_i;
      end
      supply_fail_pkg::FAIL_SAFE: begin
        ch_nxt  = to_channels(direct_f);
        ext_nxt = 1'b0;
      end
      default: begin
        ch_nxt  = supply_fail_pkg::CH_OFF;
        ext_nxt = 1'b0;
      end
    endcase
    if (!ground_ok_i) begin
      ch_nxt  = supply_fail_pkg::CH_OFF;
      ext_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ch_r   <= supply_fail_pkg::CH_OFF;
      ext_r  <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      ch_r   <= ch_nxt;
      ext_r  <= ext_nxt;
      fail_r <= fail_nxt;
    end
  end

  // Wake report state on the clock pin
  logic clk_oe_r;
  logic clk_oe_nxt;
  logic clk_lvl_r;
  logic clk_lvl_nxt;

  // Drive high only while reset pin low, awake but not woken by reset, and main supply present
  always_comb begin
    clk_oe_nxt = !active_low_reset_in_b_i
              && awake_i && !wake_by_reset_i
              && main_supply_ok_i;
    clk_lvl_nxt = clk_oe_nxt ? 1'b0 : clk_pin_i;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_oe_r  <= 1'b0;
      clk_lvl_r <= 1'b0;
    end else begin
      clk_oe_r  <= clk_oe_nxt;
      clk_lvl_r <= clk_lvl_nxt;
    end
  end

  // Status state
  logic [7:0] fault_r;
  logic [7:0] fault_nxt;
  logic [7:0] fault_evt;
  logic       spif_r;
  logic       spif_nxt;
  logic       force_lvl_r;
  logic       force_lvl_nxt;
  logic       avail_r;
  logic       avail_nxt;

  // Pack fault events into flag positions
  always_comb begin
    fault_evt = supply_fail_pkg::FAULT_RST;
    fault_evt[supply_fail_pkg::FLT_OPEN_LOAD]  = open_load_evt_i;
    fault_evt[supply_fail_pkg::FLT_SHORT_VBAT] = short_vbat_evt_i;
    fault_evt[supply_fail_pkg::FLT_SEVERE_GND] = severe_gnd_evt_i;
    fault_evt[supply_fail_pkg::FLT_OVERCUR]    = overcur_evt_i;
    fault_evt[supply_fail_pkg::FLT_OVERTEMP]   = overtemp_evt_i;
    fault_evt[supply_fail_pkg::FLT_CLOCK]      = clock_fail_evt_i;
    fault_evt[supply_fail_pkg::FLT_UNDERVOLT]  = undervolt_evt_i;
    fault_evt[supply_fail_pkg::FLT_OVERVOLT]   = overvolt_evt_i;
  end

  // Sticky flags: set beats clear, power off wipes all
  always_comb begin
    fault_nxt     = (fault_r & ~fault_clear_i) | fault_evt;
    spif_nxt      = spif_r;
    force_lvl_nxt = fail_force_i;
    avail_nxt     = logic_supply_ok_i && logic_supply_in_range_i;
    if (wd_expired_nxt && !wd_expired_r) begin
      spif_nxt = 1'b1;
    end else if (mode_r == supply_fail_pkg::FAIL_SAFE
                 && mode_nxt == supply_fail_pkg::NORMAL) begin
      spif_nxt = 1'b0;
    end
    if (power_off) begin
      fault_nxt     = supply_fail_pkg::FAULT_RST;
      spif_nxt      = 1'b0;
      force_lvl_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_r     <= supply_fail_pkg::FAULT_RST;
      spif_r      <= 1'b0;
      force_lvl_r <= 1'b0;
      avail_r     <= 1'b0;
    end else begin
      fault_r     <= fault_nxt;
      spif_r      <= spif_nxt;
      force_lvl_r <= force_lvl_nxt;
      avail_r     <= avail_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign power_channel_outputs_o = ch_r;
  assign external_switch_drive_o = ext_r;
  assign fail_mode_o             = fail_r;
  assign clk_pin_o               = clk_oe_r;
  assign clk_pin_oe_o            = clk_oe_r;
  assign clk_pin_level_o         = clk_lvl_r;
  assign spi_status_avail_o      = avail_r;
  assign spi_fail_flag_o         = spif_r;
  assign force_level_o           = force_lvl_r;
  assign fault_flags_o           = fault_r;

endmodule : supply_loss_fail_mode_control

/* File: pkg/supply_fail_pkg.sv */
// Constants, types and timing for the supply-loss and fail-mode controller
package supply_fail_pkg;

  // Clock rate and documented times
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned DGL_TIME_US  = 200;
  localparam int unsigned WD_SHORT_MS  = 32;
  localparam int unsigned WD_LONG_MS   = 128;

  // Cycle counts derived from the times
  localparam int unsigned DGL_CYC      = DGL_TIME_US * CLK_MHZ;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * 1000 * CLK_MHZ;
  localparam int unsigned WD_LONG_CYC  = WD_LONG_MS * 1000 * CLK_MHZ;

  // Counter widths
  localparam int unsigned DGL_W        = 16;
  localparam int unsigned WD_W         = 25;

  // Channel and fault flag counts
  localparam int unsigned N_CH         = 5;
  localparam int unsigned N_DIRECT     = 4;
  localparam int unsigned N_FAULT      = 8;

  // Fault flag positions
  localparam int unsigned FLT_OPEN_LOAD  = 0;
  localparam int unsigned FLT_SHORT_VBAT = 1;
  localparam int unsigned FLT_SEVERE_GND = 2;
  localparam int unsigned FLT_OVERCUR    = 3;
  localparam int unsigned FLT_OVERTEMP   = 4;
  localparam int unsigned FLT_CLOCK      = 5;
  localparam int unsigned FLT_UNDERVOLT  = 6;
  localparam int unsigned FLT_OVERVOLT   = 7;

  // Reset values
  localparam logic [N_FAULT-1:0] FAULT_RST = 8'h00;
  localparam logic [N_CH-1:0]    CH_OFF    = 5'h00;

  // Operating modes
  typedef enum logic [1:0] {
    POWER_OFF,
    MAIN_LOST,
    NORMAL,
    FAIL_SAFE
  } mode_t;

endpackage : supply_fail_pkg

/* File: sim/mcu_model.sv */
// Host model: watchdog frames and the host side of the clock pin
module mcu_model #(
  parameter int unsigned GAP = 5
) (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic kick_en_i,
  // Device side
  input  wire logic clk_pin_o,
  input  wire logic clk_pin_oe_o,
  output logic      spi_frame_ok_o,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  logic        drv;
  // One valid frame every GAP cycles, host pin level toggles
  initial begin
    cnt = 0;
    drv = 1'b0;
    spi_frame_ok_o = 1'b0;
    forever begin
      @(posedge clk_i);
      #2;
      cnt = (cnt + 1) % GAP;
      spi_frame_ok_o = kick_en_i && (cnt == 0);
      drv = !drv;
    end
  end
  // Device wins the pin while it drives, else the host level shows
  assign pin_o = clk_pin_oe_o ? clk_pin_o : drv;
endmodule : mcu_model

/* File: sim/supply_fail_asserts.sv */
// Checker for supply-loss handling, mode choice and wake reporting
module supply_fail_asserts #(
  parameter int unsigned DGL_CYC = supply_fail_pkg::DGL_CYC
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // Monitors and pins
  input wire logic       main_supply_ok_i,
  input wire logic       logic_supply_ok_i,
  input wire logic       logic_supply_in_range_i,
  input wire logic       ground_ok_i,
  input wire logic       awake_i,
  input wire logic       wake_by_reset_i,
  input wire logic       active_low_reset_in_b_i,
  input wire logic       fail_force_i,
  input wire logic [4:0] pwm_channel_i,
  input wire logic       ext_switch_cfg_i,
  // Outputs watched
  input wire logic       clk_pin_o,
  input wire logic       clk_pin_oe_o,
  input wire logic [4:0] power_channel_outputs_o,
  input wire logic       external_switch_drive_o,
  input wire logic       fail_mode_o,
  input wire logic       spi_status_avail_o,
  input wire logic       spi_fail_flag_o,
  input wire logic [7:0] fault_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0]  rc_q;
  logic [31:0] fc_q;
  logic        rdy;
  logic        held;
  assign rdy  = (rc_q == 2'h3);
  assign held = rdy && fail_force_i && main_supply_ok_i && logic_supply_ok_i && ground_ok_i;
  // Settling after reset release and length of a held force request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_q <= 2'h0;
      fc_q <= 32'h0;
    end else begin
      rc_q <= rdy ? rc_q : rc_q + 2'h1;
      fc_q <= held ? fc_q + 32'h1 : 32'h0;
    end
  end
  // Supplies good, then still in normal mode
  sequence norm_s;
    rdy && main_supply_ok_i && logic_supply_ok_i && ground_ok_i ##1 !fail_mode_o;
  endsequence
  // Main supply gone, logic supply kept
  sequence lost_s;
    rdy && !main_supply_ok_i && logic_supply_ok_i && ground_ok_i;
  endsequence
  pwm_drive_a: assert property (norm_s |-> power_channel_outputs_o == $past(pwm_channel_i))
    else $error("channels differ from pwm in normal mode");
  main_lost_a: assert property (lost_s |=> power_channel_outputs_o == 5'h00
    && external_switch_drive_o == $past(ext_switch_cfg_i))
    else $error("wrong outputs after main supply loss");
  status_kept_a: assert property (lost_s ##0 logic_supply_in_range_i |=> spi_status_avail_o)
    else $error("status lost while logic supply in range");
  no_wake_a: assert property (rdy && !main_supply_ok_i |=> !clk_pin_oe_o)
    else $error("clock pin driven without main supply");
  power_off_a: assert property (rdy && !main_supply_ok_i && !logic_supply_ok_i && ground_ok_i
    |=> power_channel_outputs_o == 5'h00 && !external_switch_drive_o && fault_flags_o == 8'h00)
    else $error("state not cleared in power off");
  ground_off_a: assert property (rdy && !ground_ok_i |=> power_channel_outputs_o == 5'h00)
    else $error("channels on after ground loss");
  wake_high_a: assert property (rdy && !active_low_reset_in_b_i && awake_i && !wake_by_reset_i
    && main_supply_ok_i |=> clk_pin_oe_o && clk_pin_o)
    else $error("wake not shown on clock pin");
  pin_input_a: assert property (rdy && (!awake_i || wake_by_reset_i) |=> !clk_pin_oe_o)
    else $error("clock pin driven in sleep or reset wake");
  force_fail_a: assert property (fc_q >= DGL_CYC + 4 |-> fail_mode_o)
    else $error("held force input did not enter fail mode");
  wd_lost_a: assert property (rdy && main_supply_ok_i && !logic_supply_ok_i && ground_ok_i
    |=> fail_mode_o && spi_fail_flag_o)
    else $error("logic supply loss did not expire watchdog");
  fail_ch4_a: assert property (fail_mode_o |-> power_channel_outputs_o[4] == 1'b0)
    else $error("fifth channel on in fail mode");
endmodule : supply_fail_asserts

bind supply_loss_fail_mode_control supply_fail_asserts #(.DGL_CYC(DGL_CYC)) u_chk (
  .clk_i, .rst_b_i, .main_supply_ok_i, .logic_supply_ok_i, .logic_supply_in_range_i,
  .ground_ok_i, .awake_i, .wake_by_reset_i, .active_low_reset_in_b_i, .fail_force_i,
  .pwm_channel_i, .ext_switch_cfg_i, .clk_pin_o, .clk_pin_oe_o, .power_channel_outputs_o,
  .external_switch_drive_o, .fail_mode_o, .spi_status_avail_o, .spi_fail_flag_o, .fault_flags_o
);

/* File: sim/tb.sv */
// Self-checking bench for the supply-loss and fail-mode controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DGL = 4;
  localparam int unsigned WS  = 20;
  localparam int unsigned WL  = 60;
  // Design inputs
  logic       clk_i, rst_b_i, main_supply_ok_i, logic_supply_ok_i, logic_supply_in_range_i;
  logic       ground_ok_i, awake_i, wake_by_reset_i, active_low_reset_in_b_i, clk_pin_i;
  logic       fail_force_i, ext_switch_cfg_i, spi_frame_ok_i, wd_sel_i, kick_en;
  logic [3:0] direct_channel_inputs_i, d;
  logic [4:0] pwm_channel_i;
  logic [7:0] evt, fault_clear_i;
  // Design outputs
  logic       clk_pin_o, clk_pin_oe_o, clk_pin_level_o, external_switch_drive_o, fail_mode_o;
  logic       spi_status_avail_o, spi_fail_flag_o, force_level_o;
  logic [4:0] power_channel_outputs_o;
  logic [7:0] fault_flags_o;
  int         bad_count = 0;
  int         check_count = 0;

  supply_loss_fail_mode_control #(.DGL_CYC(DGL), .WD_SHORT_CYC(WS), .WD_LONG_CYC(WL)) u_dut (
    .clk_i, .rst_b_i, .main_supply_ok_i, .logic_supply_ok_i, .logic_supply_in_range_i,
    .ground_ok_i, .awake_i, .wake_by_reset_i, .active_low_reset_in_b_i, .clk_pin_i,
    .clk_pin_o, .clk_pin_oe_o, .clk_pin_level_o, .fail_force_i, .direct_channel_inputs_i,
    .pwm_channel_i, .ext_switch_cfg_i, .spi_frame_ok_i, .wd_sel_i,
    .open_load_evt_i(evt[0]), .short_vbat_evt_i(evt[1]), .severe_gnd_evt_i(evt[2]),
    .overcur_evt_i(evt[3]), .overtemp_evt_i(evt[4]), .clock_fail_evt_i(evt[5]),
    .undervolt_evt_i(evt[6]), .overvolt_evt_i(evt[7]), .fault_clear_i,
    .power_channel_outputs_o, .external_switch_drive_o, .fail_mode_o, .spi_status_avail_o,
    .spi_fail_flag_o, .force_level_o, .fault_flags_o
  );
  mcu_model u_mcu (.clk_i, .kick_en_i(kick_en), .clk_pin_o, .clk_pin_oe_o,
    .spi_frame_ok_o(spi_frame_ok_i), .pin_o(clk_pin_i));

  // Expected channel drive per mode
  function automatic logic [4:0] exp_ch(input logic fl, input logic [4:0] p, input logic [3:0] x);
    return fl ? {1'b0, x} : p;
  endfunction : exp_ch
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Wait edges, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    void'($urandom(2103));
    rst_b_i = 1'b0;
    {main_supply_ok_i, logic_supply_ok_i, logic_supply_in_range_i, ground_ok_i} = 4'hF;
    {awake_i, wake_by_reset_i, fail_force_i, ext_switch_cfg_i, wd_sel_i} = 5'h00;
    {active_low_reset_in_b_i, kick_en} = 2'h3;
    {direct_channel_inputs_i, pwm_channel_i, evt, fault_clear_i} = 25'h0;
    step(5);
    rst_b_i = 1'b1;
    step(4);
    chk("idle fail", fail_mode_o, 1'b0);
    for (int i = 0; i < 20; i++) begin
      pwm_channel_i = 5'($urandom);
      step(1);
      chk("pwm", power_channel_outputs_o, exp_ch(1'b0, pwm_channel_i, 4'h0));
    end
    active_low_reset_in_b_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      {awake_i, wake_by_reset_i} = 2'(k);
      step(1);
      chk("pin oe", clk_pin_oe_o, k == 2);
      chk("pin out", clk_pin_o, k == 2);
      if (k == 2) begin
        chk("pin lvl", clk_pin_level_o, 1'b0);
      end
    end
    // One more edge so the sampled pin is the host level, not our own drive
    step(1);
    chk("pin in", clk_pin_level_o, clk_pin_i);
    {active_low_reset_in_b_i, awake_i, wake_by_reset_i} = 3'h6;
    step(1);
    chk("pin rst", clk_pin_oe_o, 1'b0);
    for (int b = 0; b < 8; b++) begin
      evt = 8'h01 << b;
      step(1);
      evt = 8'h00;
      chk("flag set", fault_flags_o, 8'h01 << b);
      fault_clear_i = 8'h01 << b;
      step(1);
      fault_clear_i = 8'h00;
      chk("flag clr", fault_flags_o, 8'h00);
    end
    evt = 8'h10;
    step(1);
    // Event and clear in one cycle: the set wins
    fault_clear_i = 8'h10;
    step(1);
    chk("set wins", fault_flags_o, 8'h10);
    {evt, fault_clear_i} = 16'h0000;
    active_low_reset_in_b_i = 1'b0;
    main_supply_ok_i = 1'b0;
    for (int c = 0; c < 2; c++) begin
      ext_switch_cfg_i = c[0];
      pwm_channel_i = 5'h1F;
      step(1);
      chk("lost ch", power_channel_outputs_o, 8'h00);
      chk("lost ext", external_switch_drive_o, c[0]);
    end
    chk("lost flags", fault_flags_o, 8'h10);
    chk("lost stat", spi_status_avail_o, 1'b1);
    chk("lost wake", clk_pin_oe_o, 1'b0);
    logic_supply_in_range_i = 1'b0;
    step(1);
    chk("range stat", spi_status_avail_o, 1'b0);
    logic_supply_ok_i = 1'b0;
    step(1);
    chk("off ch", power_channel_outputs_o, 8'h00);
    chk("off ext", external_switch_drive_o, 1'b0);
    chk("off flags", fault_flags_o, 8'h00);
    {main_supply_ok_i, logic_supply_ok_i, logic_supply_in_range_i, awake_i} = 4'hE;
    active_low_reset_in_b_i = 1'b1;
    step(8);
    ground_ok_i = 1'b0;
    step(1);
    chk("gnd ch", power_channel_outputs_o, 8'h00);
    chk("gnd ext", external_switch_drive_o, 1'b1);
    ground_ok_i = 1'b1;
    fail_force_i = 1'b1;
    step(2);
    chk("force lvl", force_level_o, 1'b1);
    fail_force_i = 1'b0;
    step(DGL + 4);
    chk("force glitch", fail_mode_o, 1'b0);
    fail_force_i = 1'b1;
    step(DGL + 4);
    chk("force fail", fail_mode_o, 1'b1);
    for (int j = 0; j < 6; j++) begin
      d = 4'($urandom);
      direct_channel_inputs_i = d;
      step(DGL + 4);
      chk("direct", power_channel_outputs_o, exp_ch(1'b1, pwm_channel_i, d));
      direct_channel_inputs_i = ~d;
      step(2);
      direct_channel_inputs_i = d;
      step(DGL + 2);
      chk("dir glitch", power_channel_outputs_o, exp_ch(1'b1, pwm_channel_i, d));
    end
    logic_supply_ok_i = 1'b0;
    step(2);
    chk("no logic", power_channel_outputs_o, exp_ch(1'b1, pwm_channel_i, d));
    logic_supply_ok_i = 1'b1;
    fail_force_i = 1'b0;
    step(DGL + 8);
    chk("force off", fail_mode_o, 1'b0);
    chk("force low", force_level_o, 1'b0);
    logic_supply_ok_i = 1'b0;
    step(1);
    chk("wd vcc", fail_mode_o, 1'b1);
    chk("wd flag", spi_fail_flag_o, 1'b1);
    logic_supply_ok_i = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wd_sel_i = s[0];
      step(12);
      kick_en = 1'b0;
      step((s ? WL : WS) / 2);
      chk("wd early", fail_mode_o, 1'b0);
      step((s ? WL : WS) / 2 + 10);
      chk("wd late", fail_mode_o, 1'b1);
      kick_en = 1'b1;
    end
    wrap_up();
  end
endmodule : tb
